/* File: hdl/clp_cold_load.sv */
/*
 Cold load pickup logic with an AHB-Lite register slave and a masked
 level interrupt. Assumes breaker position and external block arrive as
 asynchronous pins; current magnitude, undercurrent and auto-reclose flags
 come from measurement logic on hclk.
*/
`timescale 1ns/1ns
module clp_cold_load import clp_pkg::*; #(
   parameter int unsigned LOADOFF_TICKS = CLP_LOADOFF_TICKS,
   parameter int unsigned SETTLE_TICKS = CLP_SETTLE_TICKS,
   parameter int unsigned MAXBLK_TICKS = CLP_MAXBLK_TICKS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic breaker_closed_pin,
   input wire logic ext_block_pin,
   input wire logic internal_block,
   input wire logic auto_reclose_running,
   input wire logic undercurrent_seen,
   input wire logic [CLP_CUR_W-1:0] load_current,
   output logic cold_load_enable_out,
   output logic irq
);
   // A zero limit would leave a timer with nothing to count
   if (LOADOFF_TICKS == 0 || SETTLE_TICKS == 0 || MAXBLK_TICKS == 0) begin : bad_ticks_g
      $error("clp_cold_load: timer defaults must be at least one tick");
   end

   clp_cfg_type cfg_reg;
   clp_state_type state_reg, state_next;
   logic [1:0] brk_sync_reg, blk_sync_reg;
   logic [31:0] load_cnt_reg, settle_cnt_reg, maxblk_cnt_reg;
   logic inrush_reg, inrush_next;
   logic enable_next;
   logic cfg_change_reg;
   logic [CLP_EV_W-1:0] irq_stat_reg, irq_mask_reg, events;
   logic dp_write_reg, dp_valid_reg;
   logic [7:0] dp_addr_reg;
   logic addr_ok, rd_stat;
   logic cold_cond, inhibit, above_thr, below_drop;
   logic load_done, settle_done, maxblk_done;
   logic [31:0] rd_value;

   function automatic logic reached(input logic [31:0] cnt, input logic [31:0] lim);
      reached = ({1'b0, cnt} + 33'h1) >= {1'b0, lim};
   endfunction

   function automatic logic cur_below_drop(input logic [15:0] cur, input logic [15:0] thr);
      logic [19:0] lhs;
      logic [19:0] rhs;
      lhs = 20'(cur) * 20'(CLP_DROP_DEN);
      rhs = 20'(thr) * 20'(CLP_DROP_NUM);
      cur_below_drop = lhs <= rhs;
   endfunction

   // Pins come from outside the clock domain
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         brk_sync_reg <= 2'h0;
         blk_sync_reg <= 2'h0;
      end else begin
         brk_sync_reg <= {brk_sync_reg[0], breaker_closed_pin};
         blk_sync_reg <= {blk_sync_reg[0], ext_block_pin};
      end
   end

   // Unbound breaker counts as never open, so breaker-only mode stays idle
   always_comb begin
      logic brk_open;
      brk_open = cfg_reg.breaker_bound & ~brk_sync_reg[1];
      unique case (cfg_reg.mode)
         CLP_MODE_BRK_OPEN: cold_cond = brk_open;
         CLP_MODE_UNDER: cold_cond = undercurrent_seen;
         CLP_MODE_AND: cold_cond = brk_open & undercurrent_seen;
         CLP_MODE_OR: cold_cond = brk_open | undercurrent_seen;
      endcase
   end

   assign inhibit = ~cfg_reg.func_en | blk_sync_reg[1] | internal_block
      | auto_reclose_running
      | cfg_change_reg;
   assign above_thr = load_current > cfg_reg.inrush_thr;
   assign below_drop = cur_below_drop(load_current, cfg_reg.inrush_thr);
   assign load_done = reached(load_cnt_reg, cfg_reg.loadoff_ticks);
   assign settle_done = reached(settle_cnt_reg, cfg_reg.settle_ticks);
   assign maxblk_done = reached(maxblk_cnt_reg, cfg_reg.maxblk_ticks);

   always_comb begin
      state_next = state_reg;
      inrush_next = inrush_reg;
      if (inhibit) begin
         state_next = CLP_WARM;
         inrush_next = 1'b0;
      end else begin
         unique case (state_reg)
            CLP_WARM: begin
               if (cold_cond) begin
                  state_next = CLP_LOAD_OFF;
               end
            end
            CLP_LOAD_OFF: begin
               if (!cold_cond) begin
                  state_next = CLP_WARM;
               end else if (load_done) begin
                  state_next = CLP_COLD;
               end
            end
            CLP_COLD: begin
               if (!cold_cond) begin
                  state_next = CLP_SUPERVISE;
                  inrush_next = 1'b0;
               end
            end
            CLP_SUPERVISE: begin
               if (above_thr) begin
                  inrush_next = 1'b1;
               end else if (below_drop) begin
                  inrush_next = 1'b0;
               end
               if (cold_cond) begin
                  state_next = CLP_COLD;
                  inrush_next = 1'b0;
               end else if (maxblk_done) begin
                  state_next = CLP_WARM;
                  inrush_next = 1'b0;
               end else if (settle_done && !inrush_reg && below_drop) begin
                  state_next = CLP_WARM;
               end
            end
         endcase
      end
   end

   // Enable is the only output of the function; no trip path exists
   assign enable_next = (state_next == CLP_COLD) || (state_next == CLP_SUPERVISE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= CLP_WARM;
         inrush_reg <= 1'b0;
         cold_load_enable_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         inrush_reg <= inrush_next;
         cold_load_enable_out <= enable_next;
      end
   end

   // Timers count ticks and restart whenever their state is left
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_cnt_reg <= 32'h0;
         settle_cnt_reg <= 32'h0;
         maxblk_cnt_reg <= 32'h0;
      end else begin
         if (state_next == CLP_LOAD_OFF && state_reg == CLP_LOAD_OFF) begin
            load_cnt_reg <= load_cnt_reg + 32'h1;
         end else begin
            load_cnt_reg <= 32'h0;
         end
         if (state_next == CLP_SUPERVISE && state_reg == CLP_SUPERVISE) begin
            maxblk_cnt_reg <= maxblk_cnt_reg + 32'h1;
         end else begin
            maxblk_cnt_reg <= 32'h0;
         end
         // Settle time restarts on any excursion above the dropout level
         if (state_next == CLP_SUPERVISE && state_reg == CLP_SUPERVISE && !inrush_reg && below_drop) begin
            settle_cnt_reg <= settle_cnt_reg + 32'h1;
         end else begin
            settle_cnt_reg <= 32'h0;
         end
      end
   end

   // AHB-Lite slave, zero wait states
   assign addr_ok = hsel && hready && (htrans == CLP_HTRANS_NONSEQ || htrans == 2'h3);
   assign rd_stat = addr_ok && !hwrite && haddr[7:0] == CLP_IRQ_STAT_ADDR;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg <= 8'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_valid_reg <= addr_ok;
         dp_write_reg <= addr_ok && hwrite;
         if (addr_ok) begin
            dp_addr_reg <= haddr[7:0];
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   always_comb begin
      unique case (haddr[7:0])
         CLP_CTRL_ADDR: rd_value = {28'h0, cfg_reg.breaker_bound, cfg_reg.mode, cfg_reg.func_en};
         CLP_LOADOFF_ADDR: rd_value = cfg_reg.loadoff_ticks;
         CLP_SETTLE_ADDR: rd_value = cfg_reg.settle_ticks;
         CLP_MAXBLK_ADDR: rd_value = cfg_reg.maxblk_ticks;
         CLP_THR_ADDR: rd_value = {16'h0, cfg_reg.inrush_thr};
         CLP_STATUS_ADDR: rd_value = {27'h0, inhibit, state_reg == CLP_SUPERVISE, cold_cond, inrush_reg,
                                      cold_load_enable_out};
         CLP_IRQ_STAT_ADDR: rd_value = {28'h0, irq_stat_reg};
         CLP_IRQ_MASK_ADDR: rd_value = {28'h0, irq_mask_reg};
         default: rd_value = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (addr_ok && !hwrite) begin
         hrdata <= rd_value;
      end
   end

   // Any write to the configuration words clears timers through inhibit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg.func_en <= CLP_CTRL_RESET[CLP_CTRL_EN_BIT];
         cfg_reg.mode <= clp_mode_type'(CLP_CTRL_RESET[CLP_CTRL_MODE_LSB +: 2]);
         cfg_reg.breaker_bound <= CLP_CTRL_RESET[CLP_CTRL_BOUND_BIT];
         cfg_reg.loadoff_ticks <= LOADOFF_TICKS;
         cfg_reg.settle_ticks <= SETTLE_TICKS;
         cfg_reg.maxblk_ticks <= MAXBLK_TICKS;
         cfg_reg.inrush_thr <= CLP_THR_RESET;
         irq_mask_reg <= CLP_MASK_RESET;
         cfg_change_reg <= 1'b0;
      end else begin
         cfg_change_reg <= 1'b0;
         if (dp_write_reg) begin
            unique case (dp_addr_reg)
               CLP_CTRL_ADDR: begin
                  cfg_reg.func_en <= hwdata[CLP_CTRL_EN_BIT];
                  cfg_reg.mode <= clp_mode_type'(hwdata[CLP_CTRL_MODE_LSB +: 2]);
                  cfg_reg.breaker_bound <= hwdata[CLP_CTRL_BOUND_BIT];
               end
               CLP_LOADOFF_ADDR: cfg_reg.loadoff_ticks <= hwdata;
               CLP_SETTLE_ADDR: cfg_reg.settle_ticks <= hwdata;
               CLP_MAXBLK_ADDR: cfg_reg.maxblk_ticks <= hwdata;
               CLP_THR_ADDR: cfg_reg.inrush_thr <= hwdata[15:0];
               CLP_IRQ_MASK_ADDR: irq_mask_reg <= hwdata[CLP_EV_W-1:0];
               default: ;
            endcase
            if (dp_addr_reg <= CLP_THR_ADDR && dp_addr_reg[1:0] == 2'h0) begin
               cfg_change_reg <= 1'b1;
            end
         end
      end
   end

   always_comb begin
      events = '0;
      events[CLP_EV_RISE] = enable_next & ~cold_load_enable_out;
      events[CLP_EV_FALL] = ~enable_next & cold_load_enable_out;
      events[CLP_EV_INRUSH] = inrush_next & ~inrush_reg;
      events[CLP_EV_MAXBLK] = !inhibit && state_reg == CLP_SUPERVISE && !cold_cond && maxblk_done;
   end

   // Read clears, but an event in the same cycle survives the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= (rd_stat ? '0 : irq_stat_reg) | events;
         irq <= |(((rd_stat ? '0 : irq_stat_reg) | events) & irq_mask_reg);
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   enable_rise_a: assert property ($rose(cold_load_enable_out) |-> $past(state_reg) == CLP_LOAD_OFF)
      else $error("enable rose without load-off expiry");
   cold_start_a: assert property (state_reg == CLP_WARM && cold_cond && !inhibit |=> state_reg == CLP_LOAD_OFF)
      else $error("cold condition did not start load-off timer");
   inhibit_clear_a: assert property (inhibit |=> state_reg == CLP_WARM && !cold_load_enable_out)
      else $error("inhibit did not clear the function");
   supervise_start_a: assert property (state_reg == CLP_COLD && !cold_cond && !inhibit |=>
      state_reg == CLP_SUPERVISE && cold_load_enable_out && maxblk_cnt_reg == 32'h0)
      else $error("supervision did not start");
   inrush_seen_a: assert property (state_reg == CLP_SUPERVISE && above_thr && !cold_cond && !inhibit
      && !maxblk_done |=> inrush_reg)
      else $error("inrush not declared");
   settle_hold_a: assert property (inrush_reg |=> settle_cnt_reg == 32'h0)
      else $error("settle timer ran during inrush");
   maxblk_end_a: assert property (events[CLP_EV_MAXBLK] |=> !cold_load_enable_out && state_reg == CLP_WARM)
      else $error("max-block expiry did not drop enable");
   settle_end_a: assert property ($fell(cold_load_enable_out) && !$past(inhibit) && !$past(maxblk_done) |->
      $past(settle_done) && $past(below_drop))
      else $error("enable dropped before settle time");
   cfg_clear_a: assert property (dp_write_reg && dp_addr_reg == CLP_LOADOFF_ADDR |=> ##1
      state_reg == CLP_WARM && load_cnt_reg == 32'h0)
      else $error("configuration change did not clear state");
   irq_level_a: assert property (irq == $past(|(((rd_stat ? '0 : irq_stat_reg) | events) & irq_mask_reg)))
      else $error("interrupt output mismatches status and mask");
   inrush_drop_a: assert property (state_reg == CLP_SUPERVISE && inrush_reg && below_drop && !inhibit
      |=> !inrush_reg)
      else $error("inrush did not end at dropout");
   ar_inhibit_a: assert property (auto_reclose_running |=> state_reg == CLP_WARM && !cold_load_enable_out)
      else $error("auto-reclose did not inhibit the function");
   unbound_idle_a: assert property (!cfg_reg.breaker_bound && cfg_reg.mode == CLP_MODE_BRK_OPEN
      |-> !cold_cond)
      else $error("unbound breaker mode went cold");
   cold_hold_a: assert property (state_reg == CLP_COLD |-> cold_load_enable_out)
      else $error("enable low while cold");

   cold_cycle_c: cover property ($rose(cold_load_enable_out) ##[1:1000] $fell(cold_load_enable_out));
   inrush_c: cover property ($rose(inrush_reg) ##[1:1000] $fell(inrush_reg));
   maxblk_c: cover property (events[CLP_EV_MAXBLK]);
   ar_block_c: cover property (auto_reclose_running && cold_load_enable_out);
   settle_c: cover property (state_reg == CLP_SUPERVISE && settle_done && !inrush_reg && below_drop);
endmodule // clp_cold_load

/* File: pkg/clp_pkg.sv */
/*
 Package for the cold load pickup block: register map, field positions,
 reset values, timing constants, state type and configuration carrier.
 Assumes one 25 MHz system clock and an AHB-Lite register bus.
*/
package clp_pkg;
   localparam int unsigned CLP_CLK_HZ = 25_000_000;
   localparam int unsigned CLP_TICKS_PER_MS = CLP_CLK_HZ / 1000;

   // Default durations in milliseconds
   localparam int unsigned CLP_LOADOFF_MS = 1000;
   localparam int unsigned CLP_SETTLE_MS = 100;
   localparam int unsigned CLP_MAXBLK_MS = 2000;
   localparam int unsigned CLP_LOADOFF_TICKS = CLP_LOADOFF_MS * CLP_TICKS_PER_MS;
   localparam int unsigned CLP_SETTLE_TICKS = CLP_SETTLE_MS * CLP_TICKS_PER_MS;
   localparam int unsigned CLP_MAXBLK_TICKS = CLP_MAXBLK_MS * CLP_TICKS_PER_MS;

   localparam int CLP_CUR_W = 16;
   localparam logic [15:0] CLP_THR_RESET = 16'h0400;

   // Register byte addresses
   localparam logic [7:0] CLP_CTRL_ADDR = 8'h00;
   localparam logic [7:0] CLP_LOADOFF_ADDR = 8'h04;
   localparam logic [7:0] CLP_SETTLE_ADDR = 8'h08;
   localparam logic [7:0] CLP_MAXBLK_ADDR = 8'h0c;
   localparam logic [7:0] CLP_THR_ADDR = 8'h10;
   localparam logic [7:0] CLP_STATUS_ADDR = 8'h14;
   localparam logic [7:0] CLP_IRQ_STAT_ADDR = 8'h18;
   localparam logic [7:0] CLP_IRQ_MASK_ADDR = 8'h1c;

   // Control field positions
   localparam int CLP_CTRL_EN_BIT = 0;
   localparam int CLP_CTRL_MODE_LSB = 1;
   localparam int CLP_CTRL_BOUND_BIT = 3;
   localparam logic [3:0] CLP_CTRL_RESET = 4'h0;

   // Status field positions
   localparam int CLP_ST_ENABLE_BIT = 0;
   localparam int CLP_ST_INRUSH_BIT = 1;
   localparam int CLP_ST_COLD_BIT = 2;
   localparam int CLP_ST_SUPER_BIT = 3;
   localparam int CLP_ST_INHIBIT_BIT = 4;

   // Event bits of the interrupt status and mask registers
   localparam int CLP_EV_W = 4;
   localparam int CLP_EV_RISE = 0;
   localparam int CLP_EV_FALL = 1;
   localparam int CLP_EV_INRUSH = 2;
   localparam int CLP_EV_MAXBLK = 3;
   localparam logic [3:0] CLP_MASK_RESET = 4'h0;

   // Dropout ratio as a fraction: current*10 <= threshold*9
   localparam int CLP_DROP_NUM = 9;
   localparam int CLP_DROP_DEN = 10;

   localparam logic [1:0] CLP_HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {
      CLP_MODE_BRK_OPEN,
      CLP_MODE_UNDER,
      CLP_MODE_AND,
      CLP_MODE_OR
   } clp_mode_type;

   typedef enum {
      CLP_WARM,
      CLP_LOAD_OFF,
      CLP_COLD,
      CLP_SUPERVISE
   } clp_state_type;

   typedef struct packed {
      logic func_en;
      clp_mode_type mode;
      logic breaker_bound;
      logic [31:0] loadoff_ticks;
      logic [31:0] settle_ticks;
      logic [31:0] maxblk_ticks;
      logic [15:0] inrush_thr;
   } clp_cfg_type;
endpackage

/* File: verification/clp_line_model.sv */
/*
 Model of the line side: breaker auxiliary contact and current measurement.
 Assumes the bench commands breaker position and current on hclk edges.
*/
`timescale 1ns/1ns
module clp_line_model import clp_pkg::*; #(
   parameter int BRK_DELAY = 3,
   parameter logic [15:0] UC_LEVEL = 16'h0040
) (
   input wire logic hclk,
   input wire logic breaker_cmd,
   input wire logic [CLP_CUR_W-1:0] current_cmd,
   output logic breaker_closed_pin,
   output logic [CLP_CUR_W-1:0] load_current,
   output logic undercurrent_seen
);
   logic [7:0] brk_pipe_reg = 8'hff;
   logic [15:0] cur_reg = 16'h0200;
   logic uc_reg = 1'b0;
   // Contact lags the command, so the design never sees an instant breaker
   always_ff @(posedge hclk) begin
      brk_pipe_reg <= {brk_pipe_reg[6:0], breaker_cmd};
   end
   // Current comes from the transformers of the bound breaker
   always_ff @(posedge hclk) begin
      cur_reg <= current_cmd;
      uc_reg <= (current_cmd < UC_LEVEL);
   end
   assign breaker_closed_pin = brk_pipe_reg[BRK_DELAY-1];
   assign load_current = cur_reg;
   assign undercurrent_seen = uc_reg;
endmodule // clp_line_model

/* File: verification/clp_cold_load_tb.sv */
/*
 Self-checking bench for the cold load pickup block.
 Assumes short timer parameters and an AHB-Lite slave with zero wait states.
*/
`timescale 1ns/1ns
module clp_cold_load_tb import clp_pkg::*; ;
   localparam int LO = 20;
   localparam int ST = 10;
   localparam int MB = 50;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic breaker_cmd, ext_block_pin, internal_block, auto_reclose_running;
   logic breaker_closed_pin, undercurrent_seen, cold_load_enable_out, irq;
   logic [15:0] current_cmd, load_current;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   clp_cold_load #(.LOADOFF_TICKS(LO), .SETTLE_TICKS(ST), .MAXBLK_TICKS(MB)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .breaker_closed_pin(breaker_closed_pin),
      .ext_block_pin(ext_block_pin), .internal_block(internal_block),
      .auto_reclose_running(auto_reclose_running), .undercurrent_seen(undercurrent_seen),
      .load_current(load_current), .cold_load_enable_out(cold_load_enable_out), .irq(irq));

   clp_line_model u_line (.hclk(hclk), .breaker_cmd(breaker_cmd), .current_cmd(current_cmd),
      .breaker_closed_pin(breaker_closed_pin), .load_current(load_current),
      .undercurrent_seen(undercurrent_seen));

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Entered just after a rising edge; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= CLP_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      ahb(1'b0, a, 32'h0);
      check(rd, exp, what);
      check({31'h0, hresp}, 32'h0, "okay response");
   endtask

   // Warm current stays under the dropout level so no inrush is seen
   task automatic set_line(input logic closed, input logic uc);
      breaker_cmd <= closed;
      current_cmd <= uc ? 16'($urandom_range(0, 16'h3f)) : 16'($urandom_range(16'h100, 16'h380));
   endtask

   function automatic logic cold_exp(input logic [1:0] m, input logic bnd, input logic op, input logic uc);
      logic b;
      b = op & bnd;
      case (m)
         2'h0: return b;
         2'h1: return uc;
         2'h2: return b & uc;
         default: return b | uc;
      endcase
   endfunction

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         $display("unexpected at %0t: run did not finish", $time);
         stop_test;
      end
   end

   initial begin
      logic [1:0] m;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      breaker_cmd = 1'b1;
      current_cmd = 16'h0200;
      ext_block_pin = 1'b0;
      internal_block = 1'b0;
      auto_reclose_running = 1'b0;
      void'($urandom(32'h1cc1f77e));
      tick(10);
      hresetn <= 1'b1;
      tick(1);
      check(cold_load_enable_out, 1'b0, "enable after reset");
      rdchk(CLP_CTRL_ADDR, 32'h0, "ctrl reset");
      rdchk(CLP_LOADOFF_ADDR, LO, "loadoff reset");
      rdchk(CLP_SETTLE_ADDR, ST, "settle reset");
      rdchk(CLP_MAXBLK_ADDR, MB, "maxblk reset");
      rdchk(CLP_THR_ADDR, 32'h400, "thr reset");
      rdchk(CLP_IRQ_MASK_ADDR, 32'h0, "mask reset");
      rdchk(8'h20, 32'h0, "unmapped");
      $display("test reset done");
      // Every mode against every input pair, bound and unbound
      for (int i = 0; i < 32; i++) begin
         m = i[4:3];
         set_line(1'b1, 1'b0);
         tick(6);
         ahb(1'b1, CLP_CTRL_ADDR, {28'h0, i[2], m, 1'b1});
         set_line(!i[1], i[0]);
         tick(LO - 4);
         check(cold_load_enable_out, 1'b0, "enable early");
         tick(16);
         check(cold_load_enable_out, cold_exp(m, i[2], i[1], i[0]), "mode");
      end
      $display("test modes done");
      ahb(1'b1, CLP_CTRL_ADDR, 32'h3);
      set_line(1'b1, 1'b1);
      tick(LO + 12);
      check(cold_load_enable_out, 1'b1, "enable up");
      ahb(1'b0, CLP_IRQ_STAT_ADDR, 32'h0);
      current_cmd <= 16'h0500;
      tick(3);
      rdchk(CLP_STATUS_ADDR, 32'hb, "inrush status");
      tick(5);
      current_cmd <= 16'h039a;
      tick(6);
      rdchk(CLP_STATUS_ADDR, 32'hb, "above dropout");
      current_cmd <= 16'h0399;
      tick(ST - 2);
      check(cold_load_enable_out, 1'b1, "settle running");
      tick(10);
      check(cold_load_enable_out, 1'b0, "settle expiry");
      check(irq, 1'b0, "irq masked");
      ahb(1'b1, CLP_IRQ_MASK_ADDR, 32'hf);
      tick(2);
      check(irq, 1'b1, "irq unmasked");
      rdchk(CLP_IRQ_STAT_ADDR, 32'h6, "fall and inrush events");
      tick(2);
      check(irq, 1'b0, "irq cleared");
      rdchk(CLP_IRQ_STAT_ADDR, 32'h0, "status read clears");
      $display("test supervision done");
      ahb(1'b1, CLP_CTRL_ADDR, 32'h3);
      set_line(1'b1, 1'b1);
      tick(LO + 12);
      ahb(1'b0, CLP_IRQ_STAT_ADDR, 32'h0);
      current_cmd <= 16'h0600;
      tick(MB - 6);
      check(cold_load_enable_out, 1'b1, "inrush held");
      tick(14);
      check(cold_load_enable_out, 1'b0, "maxblk expiry");
      ahb(1'b0, CLP_IRQ_STAT_ADDR, 32'h0);
      check(rd & 32'h8, 32'h8, "maxblk event");
      $display("test max-block done");
      // Each block and auto-reclose inhibit input, then a timer register write as config change
      for (int s = 0; s < 4; s++) begin
         ahb(1'b1, CLP_CTRL_ADDR, 32'h3);
         set_line(1'b1, 1'b1);
         tick(LO + 12);
         check(cold_load_enable_out, 1'b1, "enable before inhibit");
         if (s == 0) ext_block_pin <= 1'b1;
         else if (s == 1) internal_block <= 1'b1;
         else if (s == 2) auto_reclose_running <= 1'b1;
         else ahb(1'b1, CLP_LOADOFF_ADDR, LO);
         tick(5);
         check(cold_load_enable_out, 1'b0, "inhibit drops");
         if (s < 3) rdchk(CLP_STATUS_ADDR, 32'h14, "inhibit status");
         tick(LO + 12);
         check(cold_load_enable_out, s == 3, "held while inhibited");
         ext_block_pin <= 1'b0;
         internal_block <= 1'b0;
         auto_reclose_running <= 1'b0;
         tick(LO + 12);
         check(cold_load_enable_out, 1'b1, "after release");
      end
      $display("test inhibit done");
      // Reset in mid-run while the load is cold and enable is up
      hresetn <= 1'b0;
      tick(2);
      check(cold_load_enable_out, 1'b0, "enable in reset");
      hresetn <= 1'b1;
      tick(1);
      rdchk(CLP_STATUS_ADDR, 32'h10, "status after reset");
      rdchk(CLP_CTRL_ADDR, 32'h0, "ctrl after reset");
      tick(LO + 12);
      check(cold_load_enable_out, 1'b0, "warm after reset");
      $display("test mid-run reset done");
      stop_test;
   end
endmodule // clp_cold_load_tb
